/* File: hw/pcsa_consts.vh */
// Constants for the program counter, return stack and indirect addressing block
// Assumes inclusion by bare name from the design files
`ifndef PCSA_CONSTS_VH
`define PCSA_CONSTS_VH
// ========================================
// Widths
`define PCSA_PC_W 13
`define PCSA_LO_W 8
`define PCSA_HI_W 5
`define PCSA_JMP_W 11
`define PCSA_PG_W 2
`define PCSA_DADDR_W 9
`define PCSA_SP_W 3
`define PCSA_DEPTH 8
// ========================================
// Data addresses (low seven bits, bank-independent)
`define PCSA_ADDR_INDIRECT 7'h00
`define PCSA_ADDR_PCL 7'h02
`define PCSA_ADDR_STATUS 7'h03
`define PCSA_ADDR_FSR 7'h04
`define PCSA_ADDR_PC_HIGH_LATCH 7'h0A
// ========================================
// Field positions and reset values
`define PCSA_STATUS_BANKHI 7
`define PCSA_PC_RST 13'h0000
`define PCSA_BYTE_RST 8'h00
`define PCSA_ZERO_BYTE 8'h00
`define PCSA_VECTOR 13'h0004
`endif

/* File: hw/pcsa_stack.v */
// Circular return stack for the program counter
// Assumes push and pop never come in the same cycle as reset
`timescale 1ns/10ps
`include "pcsa_consts.vh"
module pcsa_stack #(
  parameter WIDTH = `PCSA_PC_W,
  parameter DEPTH = `PCSA_DEPTH,
  parameter SPW = `PCSA_SP_W
) (
  input wire core_clk_i,
  input wire rst_i,
  input wire push_i,
  input wire pop_i,
  input wire [WIDTH-1:0] push_data_i,
  output wire [WIDTH-1:0] top_o
);
  // ========================================
  // Storage, kept apart from all memories
  reg [WIDTH-1:0] mem_q [0:DEPTH-1]; // Entries
  reg [SPW-1:0] sp_q; // Hidden pointer, no software path
  wire [SPW-1:0] sp_dec;
  assign sp_dec = sp_q - {{(SPW-1){1'b0}}, 1'b1};
  // Top entry for pop
  assign top_o = mem_q[sp_dec];
  // Pointer wraps freely, no overflow flags
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      sp_q <= {SPW{1'b0}};
    end else if (push_i) begin
      mem_q[sp_q] <= push_data_i; // Ninth push hits first slot
      sp_q <= sp_q + {{(SPW-1){1'b0}}, 1'b1};
    end else if (pop_i) begin
      sp_q <= sp_dec;
    end
  end
endmodule

/* File: hw/pcsa_core.v */
// Program counter, paging, return stack and indirect data addressing
// Assumes a decoder giving one-cycle strobes per executed instruction
//
// Operation
// - Program counter is thirteen bits wide
// - Low counter byte is readable writable register
// - Upper counter bits only via high latch
// - Any reset clears upper counter bits
// - Low byte write loads latch bits 4:0
// - Call/goto take top bits from latch 4:3
// - Call/goto give lower eleven bits directly
// - Eight K space split into four pages
// - Eight entry thirteen bit separate stack
// - Stack pointer hidden from software
// - Push on call and interrupt vectoring
// - Pop on return, literal, interrupt returns
// - Return restores full counter from stack
// - Push and pop leave latch unchanged
// - Stack wraps, overwriting oldest entry
// - No overflow or underflow status flag
// - Indirect port address has no storage
// - Indirect port accesses pointer's register
// - Pointer zero indirect read gives zero
// - Indirect write to port stores nothing
// - Bank bit above pointer forms address
`timescale 1ns/10ps
`include "pcsa_consts.vh"
module pcsa_core #(
  parameter PC_W = `PCSA_PC_W
) (
  input wire core_clk_i,
  input wire rst_i,
  // Sequencing strobes from the decoder
  input wire step_i,
  input wire goto_i,
  input wire call_i,
  input wire ret_i,
  input wire irq_vec_i,
  input wire [`PCSA_JMP_W-1:0] jump_addr_i,
  // Register bus
  input wire [`PCSA_DADDR_W-1:0] addr_i,
  input wire [`PCSA_LO_W-1:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [`PCSA_LO_W-1:0] rdata_o,
  // Effective data access toward file memory
  input wire [`PCSA_LO_W-1:0] file_rdata_i,
  output wire [`PCSA_DADDR_W-1:0] file_addr_o,
  output wire file_wr_o,
  output wire file_rd_o,
  output wire [`PCSA_LO_W-1:0] file_wdata_o,
  // Program fetch address and page
  output wire [PC_W-1:0] pc_o,
  output wire [`PCSA_PG_W-1:0] page_o
);
  // ========================================
  // State
  reg [PC_W-1:0] pc_q; // Counter
  reg [PC_W-1:0] pc_d;
  reg [`PCSA_LO_W-1:0] latch_q; // pc_high_latch
  reg [`PCSA_LO_W-1:0] fsr_q; // file_select_pointer
  reg bank_hi_q; // bank_select_high_bit
  wire [PC_W-1:0] stack_top;
  wire stk_push;
  wire stk_pop;
  // Bank-independent decode of a special address
  function is_reg;
    input [`PCSA_DADDR_W-1:0] a;
    input [6:0] r;
    begin
      is_reg = (a[6:0] == r);
    end
  endfunction
  // ========================================
  // Indirect addressing
  wire ind_sel;
  wire [`PCSA_DADDR_W-1:0] eff_addr;
  wire ind_self;
  assign ind_sel = is_reg(addr_i, `PCSA_ADDR_INDIRECT); // No storage here
  // Bank bit on top of pointer
  assign eff_addr = ind_sel ? {bank_hi_q, fsr_q} : addr_i;
  assign ind_self = ind_sel && is_reg(eff_addr, `PCSA_ADDR_INDIRECT);
  wire eff_pcl;
  wire eff_fsr;
  wire eff_lat;
  wire eff_sta;
  wire eff_local;
  assign eff_pcl = is_reg(eff_addr, `PCSA_ADDR_PCL) && !ind_self;
  assign eff_fsr = is_reg(eff_addr, `PCSA_ADDR_FSR) && !ind_self;
  assign eff_lat = is_reg(eff_addr, `PCSA_ADDR_PC_HIGH_LATCH) && !ind_self;
  assign eff_sta = is_reg(eff_addr, `PCSA_ADDR_STATUS) && !ind_self;
  assign eff_local = eff_pcl || eff_fsr || eff_lat || eff_sta || ind_self;
  // File memory strobes, suppressed for local and self-indirect
  assign file_addr_o = eff_addr;
  assign file_wr_o = wr_i && !eff_local;
  assign file_rd_o = rd_i && !eff_local;
  assign file_wdata_o = wdata_i;
  // ========================================
  // Read data, one cycle after the strobe
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      rdata_o <= `PCSA_BYTE_RST;
    end else if (rd_i) begin
      if (ind_self) begin
        rdata_o <= `PCSA_ZERO_BYTE; // Pointer zero reads zero
      end else if (eff_pcl) begin
        rdata_o <= pc_q[`PCSA_LO_W-1:0]; // Low byte only
      end else if (eff_fsr) begin
        rdata_o <= fsr_q;
      end else if (eff_lat) begin
        rdata_o <= latch_q;
      end else if (eff_sta) begin
        rdata_o <= {bank_hi_q, 7'h00};
      end else begin
        rdata_o <= file_rdata_i;
      end
    end else begin
      rdata_o <= `PCSA_BYTE_RST;
    end
  end
  // ========================================
  // Pointer, latch and bank bit writes
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      latch_q <= `PCSA_BYTE_RST;
      fsr_q <= `PCSA_BYTE_RST;
      bank_hi_q <= 1'b0;
    end else if (wr_i) begin
      // Latch changes only by writes, not stack moves
      if (eff_lat) begin
        latch_q <= {3'h0, wdata_i[`PCSA_HI_W-1:0]};
      end
      if (eff_fsr) begin
        fsr_q <= wdata_i;
      end
      if (eff_sta) begin
        bank_hi_q <= wdata_i[`PCSA_STATUS_BANKHI];
      end
    end
  end
  // ========================================
  // Next counter value, priority: vector, return, branch, low write, step
  // A return outranks a call in the same cycle, so no push then
  assign stk_push = irq_vec_i || (call_i && !ret_i);
  assign stk_pop = ret_i && !irq_vec_i;
  always @* begin
    pc_d = pc_q;
    if (irq_vec_i) begin
      pc_d = `PCSA_VECTOR;
    end else if (ret_i) begin
      pc_d = stack_top; // Full width, latch ignored
    end else if (goto_i || call_i) begin
      // Page from latch 4:3, offset from instruction
      pc_d = {latch_q[`PCSA_HI_W-1:`PCSA_HI_W-`PCSA_PG_W], jump_addr_i};
    end else if (wr_i && eff_pcl) begin
      // Upper bits from latch, no carry from the sum
      pc_d = {latch_q[`PCSA_HI_W-1:0], wdata_i};
    end else if (step_i) begin
      pc_d = pc_q + {{(PC_W-1){1'b0}}, 1'b1};
    end
  end
  // Counter register, cleared by every reset
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      pc_q <= `PCSA_PC_RST;
    end else begin
      pc_q <= pc_d;
    end
  end
  // Return address: next instruction for call, current one for interrupt
  wire [PC_W-1:0] ret_addr;
  assign ret_addr = irq_vec_i ? pc_q : pc_q + {{(PC_W-1){1'b0}}, 1'b1};
  // ========================================
  // Return stack
  pcsa_stack #(
    .WIDTH(PC_W),
    .DEPTH(`PCSA_DEPTH),
    .SPW(`PCSA_SP_W)
  ) u_stack (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .push_i(stk_push),
    .pop_i(stk_pop),
    .push_data_i(ret_addr),
    .top_o(stack_top)
  );
  assign pc_o = pc_q;
  assign page_o = pc_q[PC_W-1:PC_W-`PCSA_PG_W]; // Four pages
endmodule

/* File: tb/pcsa_fmem.sv */
// File memory model behind the core data port
// Assumes a combinational read in the strobe cycle
`timescale 1ns/10ps
module pcsa_fmem (
  input wire core_clk_i,
  input wire rd_i,
  input wire [8:0] addr_i,
  output wire [7:0] rdata_o
);
  reg [7:0] junk_q = 8'h5A; // Churns while unselected
  always @(posedge core_clk_i) junk_q <= ~junk_q + 8'h01;
  // Content is the low address byte, bit 8 flips bit 7
  assign rdata_o = rd_i ? addr_i[7:0] ^ {addr_i[8], 7'h00} : junk_q;
endmodule

/* File: tb/pcsa_asserts.sv */
// Port checker for pcsa_core
// Assumes binding onto the core
`timescale 1ns/10ps
module pcsa_chk (
  input wire core_clk_i, rst_i, step_i, goto_i, call_i, ret_i, irq_vec_i, wr_i, rd_i,
  input wire file_wr_o,
  input wire [10:0] jump_addr_i,
  input wire [8:0] addr_i, file_addr_o,
  input wire [7:0] wdata_i, rdata_o, file_rdata_i,
  input wire [12:0] pc_o,
  input wire [1:0] page_o
);
  wire top_w = irq_vec_i | ret_i; // Outranks jumps and writes
  wire ind_w = addr_i[6:0] == 7'h00; // Indirect port
  wire nul_w = file_addr_o[6:0] == 7'h00; // Pointer names the port itself
  wire loc_w = file_addr_o[6:0] == 7'h02 | file_addr_o[6:0] == 7'h03 |
    file_addr_o[6:0] == 7'h04 | file_addr_o[6:0] == 7'h0A; // Core-held registers
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // ====================
  page_sel_a: assert property (page_o == pc_o[12:11]) else $error("page");
  reset_pc_a: assert property ($past(rst_i) |-> pc_o == 13'h0000) else $error("rst");
  jump_lo_a: assert property ((goto_i | call_i) & !top_w |=>
    pc_o[10:0] == $past(jump_addr_i)) else $error("jump");
  vector_a: assert property (irq_vec_i |=> pc_o == 13'h0004) else $error("vec");
  step_inc_a: assert property (step_i & !top_w & !goto_i & !call_i & !wr_i |=>
    pc_o == $past(pc_o) + 13'h0001) else $error("step");
  low_wr_a: assert property (wr_i & addr_i[6:0] == 7'h02 & !top_w & !goto_i & !call_i |=>
    pc_o[7:0] == $past(wdata_i)) else $error("low");
  rd_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00) else $error("idle");
  ind_zero_a: assert property (rd_i & ind_w & nul_w |=> rdata_o == 8'h00)
    else $error("ind0");
  ind_rd_a: assert property (rd_i & ind_w & !nul_w & !loc_w |=>
    rdata_o == $past(file_rdata_i))
    else $error("ind");
  ind_wr_a: assert property (wr_i & ind_w |-> file_wr_o == (!nul_w & !loc_w))
    else $error("indw");
  cover property (call_i);
  cover property (irq_vec_i);
  cover property (rd_i & ind_w);
endmodule
bind pcsa_core pcsa_chk u_chk (.*);

/* File: tb/pcsa_core_tb.sv */
// Bench for pcsa_core: bus tasks, strobes, stack model
// Assumes pcsa_fmem answers the file port
`timescale 1ns/10ps
module pcsa_core_tb;
  reg clk = 1'h0, rst = 1'h1, st = 1'h0, go = 1'h0, ca = 1'h0, re = 1'h0, iv = 1'h0;
  reg wr = 1'h0, rd = 1'h0;
  reg [10:0] ja = 11'h000;
  reg [8:0] ad = 9'h000;
  reg [7:0] wd = 8'h00;
  reg [4:0] lat = 5'h00; // Expected latch
  reg [12:0] ep = 13'h0000; // Expected pc
  reg [12:0] stk [0:7]; // Expected stack
  reg [2:0] sp = 3'h0;
  wire [7:0] rdo, frd;
  wire [8:0] fad;
  wire fr;
  wire [12:0] pc;
  integer bad_count = 0, total_checks = 0, i;
  always #4 clk = ~clk;
  pcsa_core DUT (.core_clk_i(clk), .rst_i(rst), .step_i(st), .goto_i(go), .call_i(ca),
    .ret_i(re), .irq_vec_i(iv), .jump_addr_i(ja), .addr_i(ad), .wdata_i(wd), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdo), .file_rdata_i(frd), .file_addr_o(fad), .file_wr_o(),
    .file_rd_o(fr), .file_wdata_o(), .pc_o(pc), .page_o());
  pcsa_fmem u_mem (.core_clk_i(clk), .rd_i(fr), .addr_i(fad), .rdata_o(frd));
  task chk(input string nm, input [12:0] e, input [12:0] g);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        bad_count = bad_count + 1;
        $display("unexpected %s exp %h got %h", nm, e, g);
      end
    end
  endtask
  // Register write, then pc against the model
  task wrr(input [8:0] a, input [7:0] d);
    begin
      @(posedge clk); ad <= a; wd <= d; wr <= 1'h1;
      @(posedge clk); wr <= 1'h0;
      if (a == 9'h00A) lat = d[4:0];
      if (a == 9'h002) ep = {lat, d};
      #1 chk("pc", ep, pc);
    end
  endtask
  // Register read, data looked at in the next cycle
  task rdc(input [8:0] a, input [7:0] e);
    begin
      @(posedge clk); ad <= a; rd <= 1'h1;
      @(posedge clk); rd <= 1'h0;
      #1 chk("rdata", {5'h00, e}, {5'h00, rdo});
    end
  endtask
  // Strobe k: 0 step, 1 goto, 2 call, 3 return, 4 vector
  task op(input integer k, input [10:0] j);
    begin
      @(posedge clk); ja <= j; {iv, re, ca, go, st} <= 5'h01 << k;
      @(posedge clk); {iv, re, ca, go, st} <= 5'h00;
      case (k)
        0: ep = ep + 13'h0001;
        1: ep = {lat[4:3], j};
        2: begin stk[sp] = ep + 13'h0001; sp = sp + 3'h1; ep = {lat[4:3], j}; end
        3: begin sp = sp - 3'h1; ep = stk[sp]; end
        default: begin stk[sp] = ep; sp = sp + 3'h1; ep = 13'h0004; end
      endcase
      #1 chk("pc", ep, pc);
    end
  endtask
  task wrap_up;
    begin
      if (bad_count == 0 && total_checks > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    #1 chk("pc", 13'h0000, pc);
    wrr(9'h00A, 8'h1F);
    wrr(9'h002, 8'h34);
    rdc(9'h002, 8'h34);
    wrr(9'h00A, 8'hF8);
    rdc(9'h00A, 8'h18);
    op(1, 11'h123);
    op(2, 11'h456);
    rdc(9'h00A, 8'h18);
    op(3, 11'h000);
    for (i = 0; i < 10; i = i + 1) op(2, i * 16);
    for (i = 0; i < 9; i = i + 1) op(3, 11'h000);
    op(4, 11'h000);
    op(0, 11'h000);
    op(3, 11'h000);
    wrr(9'h002, 8'hFF);
    op(0, 11'h000);
    wrr(9'h004, 8'h00);
    rdc(9'h000, 8'h00);
    wrr(9'h000, 8'h55);
    wrr(9'h004, 8'h20);
    wrr(9'h083, 8'h80);
    rdc(9'h000, 8'hA0);
    rdc(9'h003, 8'h80);
    rdc(9'h030, 8'h30);
    wrap_up;
  end
endmodule
